/* File: logic/dpp_top.sv */
// dpp_top: two programmable three-port parallel groups behind an i/o decoder.
// assumes cpu strobes and connector inputs are synchronous to core_clk.
`timescale 1ns/10ps

module dpp_top (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             port_reset,
  input  wire logic [7:0]       io_addr,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  output logic                  io_data_oe,
  input  wire logic             io_read_n,
  input  wire logic             io_write_n,
  output logic                  group1_select_n,
  output logic                  group2_select_n,
  input  wire logic             irq_a_enable,
  input  wire logic             irq_b_enable,
  output logic                  board_irq_line_n,
  input  wire logic [7:0]       g1a_in,
  input  wire logic [7:0]       g1b_in,
  input  wire logic [7:0]       g1c_in,
  input  wire logic [7:0]       g2a_in,
  input  wire logic [7:0]       g2b_in,
  input  wire logic [7:0]       g2c_in,
  output dpp_pkg::dpp_pin_s     g1a_pins,
  output dpp_pkg::dpp_pin_s     g1b_pins,
  output dpp_pkg::dpp_pin_s     g1c_pins,
  output dpp_pkg::dpp_pin_s     g2a_pins,
  output dpp_pkg::dpp_pin_s     g2b_pins,
  output dpp_pkg::dpp_pin_s     g2c_pins,
  output logic                  g1a_xcvr_out,
  output logic                  a_buf_full
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  dpp_pkg::dpp_ctrl_s g1_ctrl, g2_ctrl;
  logic [7:0]         pa_lat, pb_lat, pc_lat, pb_in_lat, g2a_lat, g2b_lat, g2c_lat;
  logic               wr_n_q, rd_n_q, a_stb_q, a_ack_q, b_stb_q;
  logic               a_obf, a_port_irq_request_out, b_ibf, b_obf, b_port_irq_request_out;
  logic               wr_go, rd_go, g1_hit, g2_hit, clr;
  logic [1:0]         sel;
  logic               a_hs, a_mode2, a_in_side, a_out_side, b_mode1;
  logic               a_stb_fall, a_ack_fall, b_stb_fall;
  logic               a_ibf, buf_in_ready, buf_pop, port_irq_request_a, port_irq_request_b;
  logic [7:0]         buf_data, hs_own, hs_in, hs_val, g1c_rd, g2c_rd, next_rdata, next_pa_oe;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_go  = wr_n_q & ~io_write_n;
  assign rd_go  = rd_n_q & ~io_read_n;
  assign g1_hit = (io_addr[7:2] == dpp_pkg::GRP1_TAG);
  assign g2_hit = (io_addr[7:2] == dpp_pkg::GRP2_TAG);
  assign sel    = io_addr[1:0];
  assign clr    = port_reset;

  // mode views of group 1
  assign a_hs       = (g1_ctrl.a_mode != dpp_pkg::DPP_MODE0);
  assign a_mode2    = g1_ctrl.a_mode[1];
  assign a_in_side  = a_mode2 | (a_hs & g1_ctrl.a_in);
  assign a_out_side = a_mode2 | (a_hs & ~g1_ctrl.a_in);
  assign b_mode1    = g1_ctrl.b_mode;
  assign a_stb_fall = a_stb_q & ~g1c_in[dpp_pkg::PC_A_STB];
  assign a_ack_fall = a_ack_q & ~g1c_in[dpp_pkg::PC_A_ACK];
  assign b_stb_fall = b_stb_q & ~g1c_in[dpp_pkg::PC_B_STB];
  assign buf_pop    = rd_go & g1_hit & (sel == dpp_pkg::SEL_A) & a_in_side;

  // strobe edge history and cpu strobe history
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_n_q, rd_n_q, a_stb_q, a_ack_q, b_stb_q} <= 5'h1F;
    end else begin
      {wr_n_q, rd_n_q}             <= {io_write_n, io_read_n};
      {a_stb_q, a_ack_q, b_stb_q} <= {g1c_in[dpp_pkg::PC_A_STB], g1c_in[dpp_pkg::PC_A_ACK],
                                      g1c_in[dpp_pkg::PC_B_STB]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobed port A input words queue here until the cpu reads them
  dpp_buf2 #(
    .W     (8),
    .DEPTH (dpp_pkg::BUF_DEPTH)
  ) u_a_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clr       (clr | (wr_go & g1_hit & (sel == dpp_pkg::SEL_CTRL))),
    .in_valid  (a_in_side & a_stb_fall),
    .in_ready  (buf_in_ready),
    .in_data   (~g1a_in),
    .out_valid (a_ibf),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // group 1 control, latches and port C bit set/reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      g1_ctrl                  <= dpp_pkg::CTRL_RST;
      {pa_lat, pb_lat, pc_lat} <= 24'h000000;
    end else if (clr) begin
      g1_ctrl                  <= dpp_pkg::CTRL_RST;
      {pa_lat, pb_lat, pc_lat} <= 24'h000000;
    end else if (wr_go && g1_hit) begin
      case (sel)
        dpp_pkg::SEL_A: pa_lat <= io_wdata;
        dpp_pkg::SEL_B: pb_lat <= io_wdata;
        dpp_pkg::SEL_C: pc_lat <= io_wdata;
        dpp_pkg::SEL_CTRL: begin
          if (io_wdata[dpp_pkg::CW_MODE_SET]) begin
            g1_ctrl                  <= dpp_pkg::dpp_ctrl_s'(io_wdata[6:0]);
            {pa_lat, pb_lat, pc_lat} <= 24'h000000;
          end else begin
            pc_lat[io_wdata[dpp_pkg::CW_BIT_HI:dpp_pkg::CW_BIT_LO]] <=
              io_wdata[dpp_pkg::CW_BIT_VAL];
          end
        end
        default: pa_lat <= pa_lat;
      endcase
    end
  end

  // port A output handshake flags; an ack falling in the write cycle is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {a_obf, a_port_irq_request_out} <= 2'b00;
    end else if (clr || (wr_go && g1_hit && sel == dpp_pkg::SEL_CTRL)) begin
      {a_obf, a_port_irq_request_out} <= 2'b00;
    end else if (wr_go && g1_hit && sel == dpp_pkg::SEL_A && a_out_side) begin
      a_obf      <= 1'b1;
      a_port_irq_request_out <= 1'b0;
    end else if (a_ack_fall && a_obf) begin
      a_obf      <= 1'b0;
      a_port_irq_request_out <= 1'b1;
    end
  end

  // port B strobed input latch and flag; a strobe while the flag is set is dropped, even in the read cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {b_ibf, pb_in_lat} <= 9'h000;
    end else if (clr || (wr_go && g1_hit && sel == dpp_pkg::SEL_CTRL)) begin
      {b_ibf, pb_in_lat} <= 9'h000;
    end else if (b_mode1 && g1_ctrl.b_in && b_stb_fall && !b_ibf) begin
      b_ibf     <= 1'b1;
      pb_in_lat <= g1b_in;
    end else if (rd_go && g1_hit && sel == dpp_pkg::SEL_B) begin
      b_ibf     <= 1'b0;
    end
  end

  // port B output handshake flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {b_obf, b_port_irq_request_out} <= 2'b00;
    end else if (clr || (wr_go && g1_hit && sel == dpp_pkg::SEL_CTRL)) begin
      {b_obf, b_port_irq_request_out} <= 2'b00;
    end else if (wr_go && g1_hit && sel == dpp_pkg::SEL_B && b_mode1 && !g1_ctrl.b_in) begin
      b_obf      <= 1'b1;
      b_port_irq_request_out <= 1'b0;
    end else if (b_stb_fall && b_obf) begin
      b_obf      <= 1'b0;
      b_port_irq_request_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt requests; inte bits live in the port C latch
  assign port_irq_request_a = (a_in_side & pc_lat[dpp_pkg::PC_A_STB] & a_ibf) |
                  (a_out_side & pc_lat[dpp_pkg::PC_A_ACK] & a_port_irq_request_out);
  assign port_irq_request_b = b_mode1 & pc_lat[dpp_pkg::PC_B_STB] &
                  (g1_ctrl.b_in ? b_ibf : b_port_irq_request_out);

  // port C handshake ownership and values
  always_comb begin
    hs_own = 8'h00;
    hs_in  = 8'h00;
    hs_val = 8'h00;
    hs_own[dpp_pkg::PC_A_PORT_IRQ_REQUEST] = a_hs;
    hs_val[dpp_pkg::PC_A_PORT_IRQ_REQUEST] = port_irq_request_a;
    hs_in[dpp_pkg::PC_A_STB]   = a_in_side;
    hs_own[dpp_pkg::PC_A_IBF]  = a_in_side;
    hs_val[dpp_pkg::PC_A_IBF]  = a_ibf;
    hs_in[dpp_pkg::PC_A_ACK]   = a_out_side;
    hs_own[dpp_pkg::PC_A_OBF]  = a_out_side;
    hs_val[dpp_pkg::PC_A_OBF]  = ~a_obf;
    hs_own[dpp_pkg::PC_B_PORT_IRQ_REQUEST] = b_mode1;
    hs_val[dpp_pkg::PC_B_PORT_IRQ_REQUEST] = port_irq_request_b;
    hs_own[dpp_pkg::PC_B_FLAG] = b_mode1;
    hs_val[dpp_pkg::PC_B_FLAG] = g1_ctrl.b_in ? b_ibf : ~b_obf;
    hs_in[dpp_pkg::PC_B_STB]   = b_mode1;
  end

  ////////////////////////////////////////////////////////////////////////
  // port C pins per bit for both groups
  for (genvar i = 0; i < 8; i++) begin : g_pc
    localparam bit HI = (i >= 4);
    logic g1_dir_in;
    logic g2_dir_in;
    assign g1_dir_in = HI ? g1_ctrl.c_hi_in : g1_ctrl.c_lo_in;
    assign g2_dir_in = HI ? g2_ctrl.c_hi_in : g2_ctrl.c_lo_in;
    // free bits follow nibble direction; handshake bits are taken over
    assign g1c_rd[i] = hs_own[i] ? hs_val[i] : (g1_dir_in ? g1c_in[i] : pc_lat[i]);
    assign g2c_rd[i] = g2_dir_in ? g2c_in[i] : g2c_lat[i];

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        g1c_pins.dout[i] <= 1'b0;
        g1c_pins.oe[i]   <= 1'b0;
        g2c_pins.dout[i] <= 1'b0;
        g2c_pins.oe[i]   <= 1'b0;
      end else begin
        g1c_pins.dout[i] <= hs_own[i] ? hs_val[i] : pc_lat[i];
        g1c_pins.oe[i]   <= hs_own[i] | (~hs_in[i] & ~g1_dir_in);
        g2c_pins.dout[i] <= g2c_lat[i];
        g2c_pins.oe[i]   <= ~g2_dir_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // group 2: mode 0 only, strobed mode bits dropped on write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      g2_ctrl                     <= dpp_pkg::CTRL_RST;
      {g2a_lat, g2b_lat, g2c_lat} <= 24'h000000;
    end else if (clr) begin
      g2_ctrl                     <= dpp_pkg::CTRL_RST;
      {g2a_lat, g2b_lat, g2c_lat} <= 24'h000000;
    end else if (wr_go && g2_hit) begin
      case (sel)
        dpp_pkg::SEL_A: g2a_lat <= io_wdata;
        dpp_pkg::SEL_B: g2b_lat <= io_wdata;
        dpp_pkg::SEL_C: g2c_lat <= io_wdata;
        dpp_pkg::SEL_CTRL: begin
          if (io_wdata[dpp_pkg::CW_MODE_SET]) begin
            g2_ctrl        <= dpp_pkg::dpp_ctrl_s'(io_wdata[6:0]);
            g2_ctrl.a_mode <= dpp_pkg::DPP_MODE0;
            g2_ctrl.b_mode <= 1'b0;
            {g2a_lat, g2b_lat, g2c_lat} <= 24'h000000;
          end else begin
            g2c_lat[io_wdata[dpp_pkg::CW_BIT_HI:dpp_pkg::CW_BIT_LO]] <=
              io_wdata[dpp_pkg::CW_BIT_VAL];
          end
        end
        default: g2a_lat <= g2a_lat;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data selection
  always_comb begin
    next_rdata = 8'h00;
    if (g1_hit) begin
      case (sel)
        dpp_pkg::SEL_A:
          next_rdata = a_in_side ? buf_data : (g1_ctrl.a_in ? ~g1a_in : pa_lat);
        dpp_pkg::SEL_B:
          next_rdata = !g1_ctrl.b_in ? pb_lat : (b_mode1 ? pb_in_lat : g1b_in);
        dpp_pkg::SEL_C: next_rdata = g1c_rd;
        default:        next_rdata = 8'h00;
      endcase
    end else if (g2_hit) begin
      case (sel)
        dpp_pkg::SEL_A: next_rdata = g2_ctrl.a_in ? g2a_in : g2a_lat;
        dpp_pkg::SEL_B: next_rdata = g2_ctrl.b_in ? g2b_in : g2b_lat;
        dpp_pkg::SEL_C: next_rdata = g2c_rd;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  // port A drive: mode 2 enables output only while ack is low
  assign next_pa_oe = a_mode2 ? {8{~g1c_in[dpp_pkg::PC_A_ACK]}} : {8{~g1_ctrl.a_in}};

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata         <= 8'h00;
      io_data_oe       <= 1'b0;
      group1_select_n  <= 1'b1;
      group2_select_n  <= 1'b1;
      board_irq_line_n <= 1'b1;
      {g1a_pins, g1b_pins, g2a_pins, g2b_pins} <= {4{dpp_pkg::PIN_RST}};
      g1a_xcvr_out     <= 1'b0;
      a_buf_full       <= 1'b0;
    end else begin
      if (rd_go) begin
        io_rdata <= next_rdata;
      end
      io_data_oe       <= ~io_read_n & (g1_hit | g2_hit);
      group1_select_n  <= ~g1_hit;
      group2_select_n  <= ~g2_hit;
      board_irq_line_n <= ~((a_hs & irq_a_enable & port_irq_request_a) |
                            (b_mode1 & irq_b_enable & port_irq_request_b));
      g1a_pins.dout    <= ~pa_lat;
      g1a_pins.oe      <= next_pa_oe;
      g1b_pins.dout    <= pb_lat;
      g1b_pins.oe      <= {8{~g1_ctrl.b_in}};
      g2a_pins.dout    <= g2a_lat;
      g2a_pins.oe      <= {8{~g2_ctrl.a_in}};
      g2b_pins.dout    <= g2b_lat;
      g2b_pins.oe      <= {8{~g2_ctrl.b_in}};
      g1a_xcvr_out     <= next_pa_oe[0];
      a_buf_full       <= ~buf_in_ready;
    end
  end
endmodule

/* File: pkg/dpp_pkg.sv */
// dpp_pkg: shared constants and types for the dual parallel port block.
// assumes an 8-bit i/o address space and 8-bit data bus from the cpu set.
package dpp_pkg;

  // i/o addresses of the eight registers
  localparam logic [7:0] GRP1_PORT_A_DATA = 8'hE4;
  localparam logic [7:0] GRP1_PORT_B_DATA = 8'hE5;
  localparam logic [7:0] GRP1_PORT_C_DATA = 8'hE6;
  localparam logic [7:0] GRP1_CONTROL     = 8'hE7;
  localparam logic [7:0] GRP2_PORT_A_DATA = 8'hE8;
  localparam logic [7:0] GRP2_PORT_B_DATA = 8'hE9;
  localparam logic [7:0] GRP2_PORT_C_DATA = 8'hEA;
  localparam logic [7:0] GRP2_CONTROL     = 8'hEB;

  // decode tags on address bits 7..2
  localparam logic [5:0] GRP1_TAG = GRP1_PORT_A_DATA[7:2];
  localparam logic [5:0] GRP2_TAG = GRP2_PORT_A_DATA[7:2];

  // low address bits within a group
  localparam logic [1:0] SEL_A    = 2'h0;
  localparam logic [1:0] SEL_B    = 2'h1;
  localparam logic [1:0] SEL_C    = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;

  // control byte fields
  localparam int CW_MODE_SET = 7;
  localparam int CW_BIT_HI   = 3;
  localparam int CW_BIT_LO   = 1;
  localparam int CW_BIT_VAL  = 0;

  // port c handshake bit positions
  localparam int PC_B_PORT_IRQ_REQUEST = 0;
  localparam int PC_B_FLAG = 1;
  localparam int PC_B_STB  = 2;
  localparam int PC_A_PORT_IRQ_REQUEST = 3;
  localparam int PC_A_STB  = 4;
  localparam int PC_A_IBF  = 5;
  localparam int PC_A_ACK  = 6;
  localparam int PC_A_OBF  = 7;

  // buffer depth on the port A strobed input path
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    DPP_MODE0 = 2'b00,
    DPP_MODE1 = 2'b01,
    DPP_MODE2 = 2'b10,
    DPP_MODE2X = 2'b11
  } dpp_mode_e;

  // laid out exactly as control byte bits 6..0
  typedef struct packed {
    dpp_mode_e a_mode;
    logic      a_in;
    logic      c_hi_in;
    logic      b_mode;
    logic      b_in;
    logic      c_lo_in;
  } dpp_ctrl_s;

  // all ports input, mode 0
  localparam dpp_ctrl_s CTRL_RST = '{DPP_MODE0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  // one connector port: driven level and output enable
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } dpp_pin_s;

  localparam dpp_pin_s PIN_RST = '{8'h00, 8'h00};

endpackage

/* File: logic/dpp_buf2.sv */
// dpp_buf2: small valid/ready buffer, default two entries.
// assumes a single clock; clr empties it synchronously.
`timescale 1ns/10ps
module dpp_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = dpp_pkg::BUF_DEPTH
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // honest full and empty
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////
  // storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: verification/dpp_top_properties.sv */
// dpp_top_properties: pin-level timing checks for the dual port block.
// assumes one clock domain and the registered decode of the top module.
`timescale 1ns/10ps
module dpp_top_properties (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              port_reset,
  input wire logic [7:0]        io_addr,
  input wire logic              io_read_n,
  input wire logic [7:0]        io_rdata,
  input wire logic              io_data_oe,
  input wire logic              group1_select_n,
  input wire logic              group2_select_n,
  input wire logic              irq_a_enable,
  input wire logic              irq_b_enable,
  input wire logic              board_irq_line_n,
  input wire dpp_pkg::dpp_pin_s g1a_pins,
  input wire dpp_pkg::dpp_pin_s g1c_pins,
  input wire dpp_pkg::dpp_pin_s g2a_pins,
  input wire logic              g1a_xcvr_out,
  input wire logic              a_buf_full
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // address lies in either group
  logic in_grp;
  assign in_grp = io_addr[7:2] == 6'h39 || io_addr[7:2] == 6'h3A;
  ////////////////////////////////////////
  // decode, bus drive and interrupt gating
  chk_grp1_decode: assert property ($past(rst_n) |-> group1_select_n == ($past(io_addr[7:2]) != 6'h39))
    else $error("group 1 select wrong");
  chk_grp2_decode: assert property ($past(rst_n) |-> group2_select_n == ($past(io_addr[7:2]) != 6'h3A))
    else $error("group 2 select wrong");
  chk_ctrl_read_zero: assert property ($fell(io_read_n) && (io_addr == 8'hE7 || io_addr == 8'hEB) |=> io_rdata == 8'h00)
    else $error("control read not zero");
  chk_rd_drive: assert property (!io_read_n && in_grp |=> io_data_oe)
    else $error("bus not driven on read");
  chk_rd_quiet_out: assert property (!io_read_n && !in_grp |=> !io_data_oe)
    else $error("bus driven outside groups");
  chk_xcvr_tie: assert property (g1a_xcvr_out == g1a_pins.oe[0])
    else $error("transceiver direction off");
  chk_irq_gate: assert property ($past(rst_n) && $past(!irq_a_enable && !irq_b_enable) |-> board_irq_line_n)
    else $error("irq without enable");
  chk_port_clear: assert property (port_reset |-> ##2 (g1a_pins.oe == 8'h00 && g2a_pins.oe == 8'h00 && board_irq_line_n))
    else $error("port reset left drive");
  chk_full_flag: assert property (a_buf_full |-> ##[0:1] g1c_pins.dout[5])
    else $error("full buffer without ibf");
  // main scenarios reached
  cover property (!board_irq_line_n);
  cover property (a_buf_full);
  cover property (g1a_xcvr_out);
endmodule
bind dpp_top dpp_top_properties dpp_top_properties_i (.*);

/* File: verification/dpp_periph_model.sv */
// dpp_periph_model: peripherals on both edge connectors.
// assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/10ps
module dpp_periph_model (
  input  wire logic       core_clk,
  output logic      [7:0] g1a_in,
  output logic      [7:0] g1b_in,
  output logic      [7:0] g1c_in,
  output logic      [7:0] g2a_in,
  output logic      [7:0] g2b_in,
  output logic      [7:0] g2c_in
);
  ////////////////////////////////////////
  // idle: strobes and acknowledge high
  initial begin
    {g1a_in, g1b_in, g2a_in, g2b_in, g2c_in} = 40'h0;
    g1c_in = 8'hFF;
  end
  // mode 0 levels; port a is active low at the connector
  task automatic put(input logic [47:0] v);
    g1a_in = ~v[47:40];
    {g1b_in, g1c_in, g2a_in, g2b_in, g2c_in} = v[39:0];
  endtask
  // strobe one word into port a (pos 4) or b (pos 2), idle gap after
  task automatic strobe(input int pos, input logic [7:0] d, input int gap);
    @(negedge core_clk);
    if (pos == 4) g1a_in = ~d;
    else g1b_in = d;
    g1c_in[pos] = 1'b0;
    @(negedge core_clk);
    g1c_in[pos] = 1'b1;
    g1a_in = ~g1a_in; // hold over: word gone
    g1b_in = ~g1b_in;
    repeat (gap) @(negedge core_clk);
  endtask
  // acknowledge level, then wait n cycles
  task automatic ack(input logic lvl, input int n);
    g1c_in[6] = lvl;
    repeat (n) @(negedge core_clk);
  endtask
endmodule

/* File: verification/dual_parallel_port_decode_tb.sv */
// dual_parallel_port_decode_tb: self-checking bench for dpp_top.
// assumes dpp_pkg, the peripheral model and the bound checker.
`timescale 1ns/10ps
module dual_parallel_port_decode_tb;
  logic core_clk, rst_n, port_reset, io_read_n, io_write_n, irq_a_enable, irq_b_enable;
  logic [7:0] io_addr, io_wdata, io_rdata, g1a_in, g1b_in, g1c_in, g2a_in, g2b_in, g2c_in;
  logic io_data_oe, group1_select_n, group2_select_n, board_irq_line_n, g1a_xcvr_out;
  logic a_buf_full, oe_seen;
  dpp_pkg::dpp_pin_s g1a_pins, g1b_pins, g1c_pins, g2a_pins, g2b_pins, g2c_pins;
  int n_mismatch = 0;
  int comparisons = 0;
  integer seed = 32'h9de0;
  logic [7:0] d, r, w0, w1;
  logic [47:0] v;
  logic [7:0] addr_tab [6] = '{8'hE4, 8'hE5, 8'hE6, 8'hE8, 8'hE9, 8'hEA};
  logic [7:0] ref_tab [4] = '{8'hE7, 8'hEB, 8'hE3, 8'hEC};
  logic [7:0] cw_tab [4] = '{8'h88, 8'h81, 8'h89, 8'h80};
  dpp_top dpp_top_i (.*);
  dpp_periph_model dpp_periph_model_i (.*);
  ////////////////////////////////////////
  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // verdict
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write: strobe one cycle, idle until pins settle
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = x;
    io_write_n = 1'b0;
    @(negedge core_clk);
    io_write_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  // read: hold strobe until data is back
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge core_clk);
    io_addr = a;
    io_read_n = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    q = io_rdata;
    oe_seen = io_data_oe;
    io_read_n = 1'b1;
    @(negedge core_clk);
  endtask
  // port c nibble drive and read expectation
  function automatic logic [7:0] c_oe(input logic [7:0] cw);
    return {{4{~cw[3]}}, {4{~cw[0]}}};
  endfunction
  function automatic logic [7:0] c_rd(input logic [7:0] cw, input logic [7:0] p,
                                      input logic [7:0] x);
    return (p & ~c_oe(cw)) | (x & c_oe(cw));
  endfunction
  ////////////////////////////////////////
  // watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rst_n, port_reset, irq_a_enable, irq_b_enable} = 4'h0;
    {io_addr, io_wdata} = 16'h0;
    {io_read_n, io_write_n} = 2'h3;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check("g1a oe", g1a_pins.oe, 8'h00);
    check("g2c oe", g2c_pins.oe, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 48'({$random(seed), $random(seed)});
      dpp_periph_model_i.put(v);
      for (int k = 0; k < 6; k++) begin
        rd(addr_tab[k], r);
        check("port read", r, v[47-8*k -: 8]);
        check("read drive", 8'(oe_seen), 8'h01);
      end
    end
    foreach (ref_tab[k]) begin
      rd(ref_tab[k], r);
      if (k < 2) check("ctrl read", r, 8'h00);
      check("bus drive", 8'(oe_seen), k < 2 ? 8'h01 : 8'h00);
      check("sel 1", 8'(group1_select_n), k == 0 ? 8'h00 : 8'h01);
      check("sel 2", 8'(group2_select_n), k == 1 ? 8'h00 : 8'h01);
    end
    dpp_periph_model_i.put({16'h0, 8'hFF, 24'h0});
    // group 1 mode 0 outputs
    wr(8'hE7, 8'h80);
    d = 8'($random(seed));
    wr(8'hE4, d);
    wr(8'hE5, ~d);
    wr(8'hE6, d ^ 8'h5A);
    check("pa out", g1a_pins.dout, ~d);
    check("pa oe", g1a_pins.oe, 8'hFF);
    check("pb out", g1b_pins.dout, ~d);
    check("pc out", g1c_pins.dout, d ^ 8'h5A);
    // group 2 nibble splits, mode 0 settings only
    foreach (cw_tab[k]) begin
      wr(8'hEB, cw_tab[k]);
      d = 8'($random(seed));
      v = 48'({$random(seed), $random(seed)});
      dpp_periph_model_i.put({v[47:32], 8'hFF, v[23:0]});
      wr(8'hE8, d);
      wr(8'hE9, d ^ 8'h3C);
      wr(8'hEA, ~d);
      check("g2a out", g2a_pins.dout, d);
      check("g2a oe", g2a_pins.oe, 8'hFF);
      check("g2b out", g2b_pins.dout, d ^ 8'h3C);
      check("g2b oe", g2b_pins.oe, 8'hFF);
      check("g2c oe", g2c_pins.oe, c_oe(cw_tab[k]));
      check("g2c out", g2c_pins.dout & c_oe(cw_tab[k]), ~d & c_oe(cw_tab[k]));
      rd(8'hEA, r);
      check("g2c read", r, c_rd(cw_tab[k], v[7:0], ~d));
    end
    // port a strobed input: fill, refuse, drain
    wr(8'hE7, 8'hB0);
    wr(8'hE7, 8'h09);
    irq_a_enable = 1'b1;
    w0 = 8'($random(seed));
    w1 = 8'($random(seed));
    dpp_periph_model_i.strobe(4, w0, 0);
    dpp_periph_model_i.strobe(4, w1, 3);
    dpp_periph_model_i.strobe(4, ~w1, 3);
    check("ibf", 8'(g1c_pins.dout[5]), 8'h01);
    check("full", 8'(a_buf_full), 8'h01);
    check("irq a", 8'(board_irq_line_n), 8'h00);
    rd(8'hE4, r);
    check("word 0", r, w0);
    rd(8'hE4, r);
    check("word 1", r, w1);
    repeat (2) @(negedge core_clk);
    check("ibf off", 8'(g1c_pins.dout[5]), 8'h00);
    check("irq a off", 8'(board_irq_line_n), 8'h01);
    // port a bidirectional: obf and transceiver steering
    wr(8'hE7, 8'hC0);
    d = 8'($random(seed));
    wr(8'hE4, d);
    check("obf set", 8'(g1c_pins.dout[7]), 8'h00);
    dpp_periph_model_i.ack(1'b0, 3);
    check("xcvr out", 8'(g1a_xcvr_out), 8'h01);
    check("pa drive", g1a_pins.dout, ~d);
    dpp_periph_model_i.ack(1'b1, 3);
    check("xcvr in", 8'(g1a_xcvr_out), 8'h00);
    check("obf off", 8'(g1c_pins.dout[7]), 8'h01);
    // port b strobed input with its interrupt
    wr(8'hE7, 8'h86);
    wr(8'hE7, 8'h05);
    irq_a_enable = 1'b0;
    irq_b_enable = 1'b1;
    d = 8'($random(seed));
    dpp_periph_model_i.strobe(2, d, 3);
    check("b ibf", 8'(g1c_pins.dout[1]), 8'h01);
    check("b port_irq_request", 8'(g1c_pins.dout[0]), 8'h01);
    check("irq b", 8'(board_irq_line_n), 8'h00);
    rd(8'hE5, r);
    check("b word", r, d);
    // board reset line
    port_reset = 1'b1;
    @(negedge core_clk);
    port_reset = 1'b0;
    repeat (3) @(negedge core_clk);
    check("g1b oe", g1b_pins.oe, 8'h00);
    check("g1a oe", g1a_pins.oe, 8'h00);
    check("g1c oe", g1c_pins.oe, 8'h00);
    end_of_test();
  end
endmodule
